// file: core/sewc_pkg.sv
// package for the enable-controlled static memory write master
// assumes a 20 MHz system clock and a byte-wide asynchronous memory outside
package sewc_pkg;

  // clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 50000;

  // interface timing figures, in nanoseconds (slowest grade bounds the master)
  localparam int unsigned CYCLE_TIME_NS    = 35;
  localparam int unsigned ADDR_TO_END_NS   = 20;
  localparam int unsigned SELECT_WIDTH_NS  = 20;
  localparam int unsigned DATA_TO_END_NS   = 11;
  localparam int unsigned ADDR_SETUP_NS    = 0;
  localparam int unsigned DATA_HOLD_NS     = 0;

  // least times round up to whole cycles, never below one
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned SETUP_CYC  = ns_to_cyc(ADDR_SETUP_NS);
  localparam int unsigned SELECT_CYC = ns_to_cyc(SELECT_WIDTH_NS);
  localparam int unsigned ADDR_CYC   = ns_to_cyc(ADDR_TO_END_NS);
  localparam int unsigned DATA_CYC   = ns_to_cyc(DATA_TO_END_NS);
  localparam int unsigned HOLD_CYC   = ns_to_cyc(DATA_HOLD_NS);
  localparam int unsigned CYCLE_CYC  = ns_to_cyc(CYCLE_TIME_NS);

  // select pulse covers address-to-end and data-to-end as well
  localparam int unsigned PULSE_CYC =
    (SELECT_CYC > ADDR_CYC) ? ((SELECT_CYC > DATA_CYC) ? SELECT_CYC : DATA_CYC)
                            : ((ADDR_CYC > DATA_CYC) ? ADDR_CYC : DATA_CYC);

  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // memory geometry defaults
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 8;

  // write request carried from the user side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sewc_req_t;

  // memory-side pins bundled
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              dq_oe;
    logic              select_low_active_n;
    logic              select_high_active;
    logic              write_n;
    logic              output_en_n;
  } sewc_pins_t;

  typedef enum logic [1:0] {
    SEWC_IDLE,
    SEWC_SETUP,
    SEWC_PULSE,
    SEWC_RECOVER
  } sewc_state_t;

endpackage

// file: core/sewc_master.sv
// write master that ends each write by releasing the combined select
// assumes inputs synchronous to clk_i and a memory with no clock of its own
//
// What this block does
// (RULE_01) write happens during select and strobe overlap
// (RULE_02) select means low input low, high input high
// (RULE_03) output enable held high, data pins stay released
// (RULE_04) strobe falls before select asserts
// (RULE_05) select deasserts before strobe rises
// (RULE_06) successive writes spaced by full cycle time
// (RULE_07) address valid long enough before select ends
// (RULE_08) select held for minimum pulse width
// (RULE_09) data valid before end, zero hold after
// (RULE_10) avoid both sides driving data pins
// (RULE_11) address and data steady through overlap
`timescale 1ns/1ps

module sewc_master
  import sewc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // user write request
  input  wire logic              req_valid_i,
  input  wire sewc_req_t         req_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  // memory pins
  output sewc_pins_t             pins_o
);

  sewc_state_t      state;
  logic [CNT_W-1:0] cnt;
  sewc_req_t        hold;

  // pin flops; the port bundle is only wiring over these
  logic [ADDR_W-1:0] pin_addr;
  logic [DATA_W-1:0] pin_dout;
  logic              pin_dq_oe;
  logic              pin_sel_n;
  logic              pin_sel_h;
  logic              pin_write_n;
  logic              pin_oe_n;

  // one-cycle events of the sequencer, shared by the pin processes
  logic              take;
  logic              setup_end;
  logic              pulse_end;
  logic              recover_start;

  // take only in idle; requests in any other state are dropped on purpose
  always_comb begin
    take          = (state == SEWC_IDLE) && req_valid_i;
    setup_end     = (state == SEWC_SETUP) && (cnt == CNT_ZERO);
    pulse_end     = (state == SEWC_PULSE) && (cnt == CNT_ZERO);
    recover_start = (state == SEWC_RECOVER) && (cnt == CNT_W'(CYCLE_CYC - 1));
  end

  // cycle walk with the default figures, e0 being the take edge:
  //   e0: address and data out, data lines driven, strobe low
  //   e1: combined select on, the store window opens
  //   e2: combined select off, the store window closes
  //   e3: strobe high, data lines released, done pulse
  //   e4: back in idle, next request may be taken
  // slowest-grade figures keep any fitted grade safe;
  // the cost is a longer cycle on fast parts

  // sequencer: strobe low, select on, select off, strobe high, recover
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= SEWC_IDLE;
      cnt   <= CNT_ZERO;
    end else begin
      unique case (state)
        SEWC_IDLE: begin
          if (req_valid_i) begin
            state <= SEWC_SETUP;
            cnt   <= CNT_W'(SETUP_CYC - 1);
          end
        end
        SEWC_SETUP: begin
          if (cnt == CNT_ZERO) begin
            state <= SEWC_PULSE; // RULE_04
            cnt   <= CNT_W'(PULSE_CYC - 1); // RULE_08
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        SEWC_PULSE: begin
          if (cnt == CNT_ZERO) begin
            state <= SEWC_RECOVER; // RULE_05
            cnt   <= CNT_W'(CYCLE_CYC - 1); // RULE_06
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        SEWC_RECOVER: begin
          if (cnt == CNT_ZERO) begin
            state <= SEWC_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
      endcase
    end
  end

  // request capture; frozen for the whole cycle so one location is hit
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold <= '0;
    end else if (state == SEWC_IDLE && req_valid_i) begin
      hold <= req_i; // RULE_11
    end
  end

  // ready is advisory only: a valid seen in idle is taken regardless
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (state == SEWC_IDLE) && !req_valid_i;
    end
  end

  // done pulses once, on the edge that ends recovery
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (state == SEWC_RECOVER) && (cnt == CNT_ZERO);
    end
  end

  // address: launched on take and held through recovery, so it
  // never moves inside the store window
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_addr <= '0;
    end else if (take) begin
      pin_addr <= req_i.addr; // RULE_07
    end else if (recover_start) begin
      pin_addr <= hold.addr; // RULE_11
    end
  end

  // write data: same timing as the address; still driven a cycle after select falls
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_dout <= '0;
    end else if (take) begin
      pin_dout <= req_i.data; // RULE_09
    end else if (recover_start) begin
      pin_dout <= hold.data; // RULE_11
    end
  end

  // data line drive: on before the select, off on the same edge the strobe rises
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_dq_oe <= 1'b0;
    end else if (take) begin
      pin_dq_oe <= 1'b1; // RULE_10
    end else if (recover_start) begin
      pin_dq_oe <= 1'b0; // RULE_09
    end
  end

  // combined select: both inputs move on one edge, never half on
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_sel_n <= 1'b1;
      pin_sel_h <= 1'b0;
    end else if (setup_end) begin
      pin_sel_n <= 1'b0; // RULE_02
      pin_sel_h <= 1'b1; // RULE_01
    end else if (pulse_end) begin
      // write ends by select only; strobe rises a cycle later
      pin_sel_n <= 1'b1; // RULE_05
      pin_sel_h <= 1'b0; // RULE_08
    end
  end

  // strobe: falls on take, a cycle ahead of the select, rises after it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_write_n <= 1'b1;
    end else if (take) begin
      pin_write_n <= 1'b0; // RULE_04
    end else if (recover_start) begin
      pin_write_n <= 1'b1; // RULE_05
    end
  end

  // output enable never asserted; this block only writes, so the
  // memory never drives the data lines against us
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_oe_n <= 1'b1; // RULE_03
    end else begin
      pin_oe_n <= 1'b1; // RULE_03
    end
  end

  // pin bundle is pure wiring over the flops above
  assign pins_o = '{
    addr:                pin_addr,
    dout:                pin_dout,
    dq_oe:               pin_dq_oe,
    select_low_active_n: pin_sel_n,
    select_high_active:  pin_sel_h,
    write_n:             pin_write_n,
    output_en_n:         pin_oe_n
  };

endmodule

// file: bench/sewc_monitor.sv
// pin sequence checker for the write master
// assumes one clock domain, reset low while asserted
`timescale 1ns/1ps
module sewc_monitor
  import sewc_pkg::*;
(
  // clock, reset and user side
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       req_valid_i,
  input  wire logic       req_ready_o,
  input  wire logic       done_o,
  // memory pins
  input  wire sewc_pins_t pins_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // combined select as the memory decodes it
  wire sel = !pins_o.select_low_active_n && pins_o.select_high_active;
  wire wl  = !pins_o.write_n;
  sequence s_take; req_ready_o && req_valid_i; endsequence
  sequence s_wr; wl && !sel ##1 wl && sel ##1 wl && !sel; endsequence
  property p_take; s_take |=> s_wr; endproperty
  a_take: assert property (p_take) else $error("bad write");
  property p_pair; pins_o.select_low_active_n == !pins_o.select_high_active; endproperty
  a_pair: assert property (p_pair) else $error("bad pair");
  property p_rise; $rose(sel) |-> $past(wl); endproperty
  a_rise: assert property (p_rise) else $error("late strobe");
  property p_fall; $fell(sel) |-> wl ##1 !wl && done_o; endproperty
  a_fall: assert property (p_fall) else $error("bad end");
  property p_gap; $fell(sel) |-> !sel [*3]; endproperty
  a_gap: assert property (p_gap) else $error("short gap");
  property p_addr; sel |-> $stable(pins_o.addr) && $stable(pins_o.dout); endproperty
  a_addr: assert property (p_addr) else $error("moved");
  property p_hold; $fell(sel) |-> pins_o.dq_oe && $stable(pins_o.dout); endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_cont; pins_o.dq_oe |-> pins_o.output_en_n; endproperty
  a_cont: assert property (p_cont) else $error("contention");
endmodule

bind sewc_master sewc_monitor u_mon (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .done_o(done_o), .pins_o(pins_o));

// file: bench/sewc_sram_model.sv
// behavioural byte memory written in the select and strobe overlap
// assumes the master's pin bundle; no clock of its own
`timescale 1ns/1ps
module sewc_sram_model
  import sewc_pkg::*;
(
  // memory pins
  input  wire sewc_pins_t        pins_i,
  inout  wire logic [DATA_W-1:0] dq_io
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  // low input low and high input high selects
  wire sel = !pins_i.select_low_active_n && pins_i.select_high_active;
  // last value seen in the overlap wins
  always @* if (sel && !pins_i.write_n) mem[pins_i.addr] = dq_io;
  // drives only in a read, so released all through a write
  wire rd = sel && pins_i.write_n && !pins_i.output_en_n;
  assign dq_io = rd ? mem[pins_i.addr] : 'z;
endmodule

// file: bench/sewc_master_bench.sv
// scenario bench for the write master against the memory model
// assumes the package and memory model compiled first
`timescale 1ns/1ps
module sewc_master_bench
  import sewc_pkg::*;
;
  logic       clk_i = 1'b0, arst_n_i = 1'b0, req_valid_i = 1'b0;
  sewc_req_t  req_i = '0;
  logic       req_ready_o, done_o;
  sewc_pins_t pins_o;
  wire [DATA_W-1:0] dq;
  int error_cnt = 0, n_compared = 0;
  sewc_master dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .pins_o(pins_o));
  sewc_sram_model mem (.pins_i(pins_o), .dq_io(dq));
  // master drive onto the shared data lines
  assign dq = pins_o.dq_oe ? pins_o.dout : 'z;
  initial forever #25 clk_i = ~clk_i;
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one request, held one edge; a is sent as 17 bits, d as 8
  task automatic go(logic [16:0] a, logic [7:0] d);
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_i = '{addr: a, data: d};
    @(negedge clk_i);
  endtask
  task automatic t_write(logic [16:0] a, logic [7:0] d);
    int n;
    go(a, d);
    req_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 9) begin
      @(negedge clk_i);
      n++;
    end
    chk("done", 8'h03, 8'(n));
    chk("mem", d, mem.mem[a]);
  endtask
  // a request while busy must be ignored
  task automatic t_busy();
    go(17'h00011, 8'h11);
    chk("ready", 8'h00, {7'h0, req_ready_o});
    req_i = '{addr: 17'h00055, data: 8'h33};
    @(negedge clk_i);
    req_valid_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("busy", 8'hxx, mem.mem[17'h00055]);
    chk("first", 8'h11, mem.mem[17'h00011]);
    chk("ready", 8'h01, {7'h0, req_ready_o});
  endtask
  // reset before the select comes: no store, pins idle
  task automatic t_abort();
    go(17'h00077, 8'h77);
    req_valid_i = 1'b0;
    arst_n_i = 1'b0;
    @(negedge clk_i);
    chk("wr_n", 8'h01, {7'h0, pins_o.write_n});
    chk("oe", 8'h00, {7'h0, pins_o.dq_oe});
    arst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("abort", 8'hxx, mem.mem[17'h00077]);
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_write(17'h00000, 8'h00);
    t_write(17'h1ffff, 8'hff);
    t_busy();
    t_abort();
    t_write(17'h0a5c3, 8'h5a);
    end_sim();
  end
  // generous span for about forty cycles of tests
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
endmodule
